// [hdl/sdes_pkg.sv]
// Constants for the DRAM data, strobe and alert pin logic
package sdes_pkg;
    localparam int DQ_W = 16;
    localparam int CA_W = 23;
    localparam int MR2_TSTROBE_BIT = 11;
    localparam int MR5_VREFMON_BIT = 4;
    localparam int VREF_DQ_IDX = 2;
    localparam int CRC_ALERT_NS = 40;
    localparam int PAR_ALERT_NS = 400;
    localparam int CLK_PS = 5000;
    localparam int CRC_ALERT_CYC = (CRC_ALERT_NS * 1000) / CLK_PS;
    localparam int PAR_ALERT_CYC = (PAR_ALERT_NS * 1000) / CLK_PS;
    localparam logic [1:0] IRQ_CRC = 2'h1;
    localparam logic [1:0] IRQ_PAR = 2'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h1;
    localparam logic [3:0] ADDR_CTRL = 4'h2;
    localparam logic [3:0] ADDR_CRC = 4'h3;
    localparam logic [3:0] ADDR_WDATA = 4'h4;
    localparam logic [3:0] ADDR_RDATA = 4'h5;
    localparam int CTRL_CRC_EN = 0;
    localparam int CTRL_PAR_EN = 1;
    localparam int CTRL_VREFMON = 2;
    localparam int CTRL_TSTROBE = 3;
    localparam int CTRL_MASK_SEL = 4;
    localparam int CTRL_INV_SEL = 5;
    localparam int CTRL_WIDE = 6;
    localparam int CTRL_DRIVE = 7;
    localparam int CTRL_CRC_ERR = 8;
endpackage : sdes_pkg

// [hdl/sdes_pins.sv]
// Data, strobe, parity and alert pin logic of the memory device
`timescale 1ns/1ps
module sdes_pins
    import sdes_pkg::*;
#(
    parameter bit IS_X16 = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata_r,
    output logic irq_r,
    input wire logic [DQ_W-1:0] dqIn,
    output logic [DQ_W-1:0] dqOut_r,
    output logic [DQ_W-1:0] dqOe_r,
    input wire logic lowerByteStrobeT,
    input wire logic lowerByteStrobeC,
    input wire logic upperByteStrobeT,
    input wire logic upperByteStrobeC,
    output logic lowerStrobeOutT_r,
    output logic lowerStrobeOutC_r,
    output logic upperStrobeOutT_r,
    output logic upperStrobeOutC_r,
    output logic strobeOe_r,
    input wire logic [1:0] writeMaskIn,
    output logic [1:0] busInvOut_r,
    output logic busInvOe_r,
    output logic termStrobeTermEn_r,
    input wire logic vrefLevel,
    input wire logic lineTerminationOn,
    input wire logic csIn_b,
    input wire logic [CA_W-1:0] cmdAddrIn,
    input wire logic cmdAddrParityIn,
    input wire logic connectivityTestEnable,
    input wire logic alertIn,
    output logic alertOut_b_r,
    output logic alertOe_r,
    output logic alertSeen_r
);
    initial begin
        if (CRC_ALERT_CYC < 1 || PAR_ALERT_CYC <= CRC_ALERT_CYC)
            $error("Alert pulse widths unusable");
    end

    // Two-flop synchronisers for pins
    logic [DQ_W-1:0] dqS1, dqS2;
    logic [3:0] dqsS1, dqsS2, dqsD;
    logic [1:0] dmS1, dmS2;
    logic [CA_W+1:0] caS1, caS2;
    logic tenS1, tenS2, alS1, alS2, vrS1, vrS2, rtS1, rtS2;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dqS1 <= '0; dqS2 <= '0; dqsS1 <= 4'h0; dqsS2 <= 4'h0;
            dqsD <= 4'h0; dmS1 <= 2'h3; dmS2 <= 2'h3;
            caS1 <= '1; caS2 <= '1; tenS1 <= 1'b0; tenS2 <= 1'b0;
            alS1 <= 1'b1; alS2 <= 1'b1; vrS1 <= 1'b0; vrS2 <= 1'b0;
            rtS1 <= 1'b0; rtS2 <= 1'b0;
        end else begin
            dqS1 <= dqIn; dqS2 <= dqS1;
            dqsS1 <= {upperByteStrobeT, upperByteStrobeC,
                      lowerByteStrobeT, lowerByteStrobeC};
            dqsS2 <= dqsS1; dqsD <= dqsS2;
            dmS1 <= writeMaskIn; dmS2 <= dmS1;
            caS1 <= {csIn_b, cmdAddrParityIn, cmdAddrIn}; caS2 <= caS1;
            tenS1 <= connectivityTestEnable; tenS2 <= tenS1;
            alS1 <= alertIn; alS2 <= alS1;
            vrS1 <= vrefLevel; vrS2 <= vrS1;
            rtS1 <= lineTerminationOn; rtS2 <= rtS1;
        end
    end

    // Control register and software-visible state
    logic [15:0] ctrl_r, mask_r, wdata_r, rdata_r, crcCode_r;
    logic [1:0] status_r;
    logic crcEv, parEv;
    wire wrCtrl = regWr && regAddr == ADDR_CTRL;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= 16'h0000; mask_r <= 16'h0000;
            wdata_r <= 16'h0000; crcCode_r <= 16'h0000;
        end else if (regWr) begin
            if (regAddr == ADDR_CTRL) ctrl_r <= regWdata;
            if (regAddr == ADDR_MASK) mask_r <= regWdata;
            if (regAddr == ADDR_WDATA) wdata_r <= regWdata;
            if (regAddr == ADDR_CRC) crcCode_r <= regWdata;
        end
    end
    // Set wins over write-one-to-clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) status_r <= 2'h0;
        else status_r <= (status_r & ~((regWr && regAddr == ADDR_STATUS)
            ? regWdata[1:0] : 2'h0)) | (crcEv ? IRQ_CRC : 2'h0)
            | (parEv ? IRQ_PAR : 2'h0);
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) irq_r <= 1'b0;
        else irq_r <= |(status_r & mask_r[1:0]);
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) regRdata_r <= 16'h0000;
        else if (regRd) begin
            unique case (regAddr)
                ADDR_STATUS: regRdata_r <= {14'h0000, status_r};
                ADDR_MASK: regRdata_r <= mask_r;
                ADDR_CTRL: regRdata_r <= ctrl_r;
                ADDR_CRC: regRdata_r <= crcCode_r;
                ADDR_WDATA: regRdata_r <= wdata_r;
                ADDR_RDATA: regRdata_r <= rdata_r;
                default: regRdata_r <= 16'h0000;
            endcase
        end else regRdata_r <= 16'h0000;
    end

    wire testMode = IS_X16 && tenS2;
    wire tstrobeOn = !IS_X16 && ctrl_r[CTRL_TSTROBE];
    wire vrefMon = ctrl_r[CTRL_VREFMON] && !rtS2;

    // Write capture on true strobe rise, complement fall
    function automatic logic strobeEdge(input logic [1:0] now,
                                        input logic [1:0] was);
        strobeEdge = (now == 2'b10) && (was != 2'b10);
    endfunction
    logic [1:0] capEdge;
    assign capEdge[0] = strobeEdge(dqsS2[1:0], dqsD[1:0]);
    assign capEdge[1] = strobeEdge(dqsS2[3:2], dqsD[3:2]);
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gByte
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) rdata_r[g*8 +: 8] <= 8'h00;
                else if (capEdge[g] && !ctrl_r[CTRL_DRIVE]) begin
                    if (!tstrobeOn && ctrl_r[CTRL_MASK_SEL]
                        && !dmS2[g]) begin
                        rdata_r[g*8 +: 8] <= rdata_r[g*8 +: 8];
                    end else if (!tstrobeOn && ctrl_r[CTRL_INV_SEL]
                        && !dmS2[g]) begin
                        rdata_r[g*8 +: 8] <= ~dqS2[g*8 +: 8];
                    end else begin
                        rdata_r[g*8 +: 8] <= dqS2[g*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    // Read drive: strobe toggles with each beat, edge aligned
    logic [1:0] beat_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) beat_r <= 2'h0;
        else if (ctrl_r[CTRL_DRIVE] && !testMode) beat_r <= beat_r + 2'h1;
        else beat_r <= 2'h0;
    end
    wire crcBeat = ctrl_r[CTRL_CRC_EN] && beat_r == 2'h3;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dqOut_r <= '0; dqOe_r <= '0;
        end else if (vrefMon) begin
            dqOut_r <= '0;
            dqOut_r[VREF_DQ_IDX] <= vrS2;
            dqOe_r <= '0;
            dqOe_r[VREF_DQ_IDX] <= 1'b1;
        end else if (ctrl_r[CTRL_DRIVE] && !testMode) begin
            dqOut_r <= crcBeat ? crcCode_r : wdata_r;
            dqOe_r <= '1;
        end else begin
            dqOut_r <= '0; dqOe_r <= '0;
        end
    end
    wire drv = ctrl_r[CTRL_DRIVE] && !testMode && !vrefMon;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lowerStrobeOutT_r <= 1'b0; lowerStrobeOutC_r <= 1'b1;
            upperStrobeOutT_r <= 1'b0; upperStrobeOutC_r <= 1'b1;
            strobeOe_r <= 1'b0;
        end else begin
            lowerStrobeOutT_r <= drv & ~beat_r[0];
            lowerStrobeOutC_r <= ~(drv & ~beat_r[0]);
            upperStrobeOutT_r <= drv & ~beat_r[0];
            upperStrobeOutC_r <= ~(drv & ~beat_r[0]);
            strobeOe_r <= drv;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busInvOut_r <= 2'h3; busInvOe_r <= 1'b0;
            termStrobeTermEn_r <= 1'b0;
        end else begin
            busInvOut_r <= 2'h3;
            busInvOe_r <= drv && !tstrobeOn && ctrl_r[CTRL_INV_SEL];
            termStrobeTermEn_r <= tstrobeOn && rtS2 && !drv;
        end
    end

    // Parity: even over command/address plus parity bit
    assign parEv = ctrl_r[CTRL_PAR_EN] && !caS2[CA_W+1]
                   && (^caS2[CA_W:0]);
    assign crcEv = wrCtrl && regWdata[CTRL_CRC_ERR];
    logic [15:0] alertCnt_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) alertCnt_r <= 16'h0000;
        else if (parEv) alertCnt_r <= 16'(PAR_ALERT_CYC);
        else if (crcEv && alertCnt_r == 16'h0000)
            alertCnt_r <= 16'(CRC_ALERT_CYC);
        else if (alertCnt_r != 16'h0000) alertCnt_r <= alertCnt_r - 16'h1;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alertOut_b_r <= 1'b1; alertOe_r <= 1'b0; alertSeen_r <= 1'b1;
        end else begin
            alertOe_r <= !testMode && alertCnt_r != 16'h0000;
            alertOut_b_r <= 1'b0;
            alertSeen_r <= testMode ? alS2 : 1'b1;
        end
    end

    a_crc_alert_len: assert property (@(posedge mclk) disable iff (!rst_b)
        crcEv && alertCnt_r == 0 && !parEv && !testMode
        |=> alertCnt_r == 16'(CRC_ALERT_CYC))
        else $error("Checksum alert length wrong");
    a_par_alert_len: assert property (@(posedge mclk) disable iff (!rst_b)
        parEv |=> alertCnt_r == 16'(PAR_ALERT_CYC))
        else $error("Parity alert length wrong");
    a_par_detect: assert property (@(posedge mclk) disable iff (!rst_b)
        ctrl_r[CTRL_PAR_EN] && !caS2[CA_W+1] && ^caS2[CA_W:0]
        |=> status_r[1])
        else $error("Parity error not flagged");
    a_alert_test_in: assert property (@(posedge mclk) disable iff (!rst_b)
        testMode |=> !alertOe_r)
        else $error("Alert driven in test mode");
    a_vref_drive: assert property (@(posedge mclk)
        disable iff (!rst_b) vrefMon
        |=> dqOe_r[VREF_DQ_IDX] && dqOut_r[VREF_DQ_IDX] == $past(vrS2))
        else $error("Reference level not on line two");
    // Only line two may be driven while the reference is shown
    a_vref_only_two: assert property (@(posedge mclk)
        disable iff (!rst_b) vrefMon
        |=> dqOe_r == (DQ_W'(1) << VREF_DQ_IDX))
        else $error("Other data lines driven during monitor");
    // Drive must be checked too: a beat count can outlive the drive bit
    a_crc_beat: assert property (@(posedge mclk) disable iff (!rst_b)
        crcBeat && drv |=> dqOut_r == $past(crcCode_r))
        else $error("Checksum beat missing");
    a_read_data: assert property (@(posedge mclk)
        disable iff (!rst_b) drv && !crcBeat
        |=> dqOe_r == '1 && dqOut_r == $past(wdata_r))
        else $error("Read burst data wrong");
    a_strobe_oe: assert property (@(posedge mclk)
        disable iff (!rst_b) drv |=> strobeOe_r)
        else $error("Strobe not driven with read data");
    a_mask_keep: assert property (@(posedge mclk)
        disable iff (!rst_b) capEdge[0] && !ctrl_r[CTRL_DRIVE]
        && !tstrobeOn && ctrl_r[CTRL_MASK_SEL] && !dmS2[0]
        |=> $stable(rdata_r[7:0]))
        else $error("Masked byte was stored");
    a_inv_store: assert property (@(posedge mclk)
        disable iff (!rst_b) capEdge[0] && !ctrl_r[CTRL_DRIVE]
        && !tstrobeOn && !ctrl_r[CTRL_MASK_SEL]
        && ctrl_r[CTRL_INV_SEL] && !dmS2[0]
        |=> rdata_r[7:0] == ~$past(dqS2[7:0]))
        else $error("Inverted byte not complemented");
    a_crc_alert_end: assert property (@(posedge mclk)
        disable iff (!rst_b) alertCnt_r == 16'h0001 && !parEv && !crcEv
        |=> alertCnt_r == 16'h0000)
        else $error("Checksum alert does not release");
    a_alert_drive: assert property (@(posedge mclk)
        disable iff (!rst_b) !testMode && alertCnt_r != 16'h0000
        |=> alertOe_r && !alertOut_b_r)
        else $error("Alert not pulled low");
    a_test_seen: assert property (@(posedge mclk)
        disable iff (!rst_b) testMode |=> alertSeen_r == $past(alS2))
        else $error("Alert pin not read in test mode");
    a_term_follow: assert property (@(posedge mclk)
        disable iff (!rst_b) tstrobeOn && rtS2 && !drv
        |=> termStrobeTermEn_r)
        else $error("Termination strobe not terminated");
    a_strobe_diff: assert property (@(posedge mclk) disable iff (!rst_b)
        lowerStrobeOutT_r != lowerStrobeOutC_r
        && upperStrobeOutT_r != upperStrobeOutC_r)
        else $error("Strobe pair not complementary");
    a_x8_no_test: assert property (@(posedge mclk) disable iff (!rst_b)
        !IS_X16 |-> !testMode)
        else $error("Test mode on x8");
    a_tstrobe_off: assert property (@(posedge mclk) disable iff (!rst_b)
        tstrobeOn |=> !busInvOe_r)
        else $error("Inversion driven with termination strobe");
endmodule : sdes_pins

// [dv/sdes_ctrl_model.sv]
// Controller-side model: write strobes, write data and command bus
`timescale 1ns/1ps
module sdes_ctrl_model (
    output logic [15:0] dq,
    output logic lT,
    output logic lC,
    output logic uT,
    output logic uC,
    output logic [1:0] msk,
    output logic csB,
    output logic [22:0] ca,
    output logic par
);
    initial begin
        dq = 16'h0;
        {lT, lC, uT, uC} = 4'h5;
        msk = 2'h3;
        csB = 1'b1;
        ca = 23'h0;
        par = 1'b0;
    end
    // One beat per 48 ns strobe period; strobe idles still between beats
    task automatic beat(input logic [15:0] d, input logic [1:0] m);
        dq = d;
        msk = m;
        #12 {lT, lC, uT, uC} = 4'ha;
        #24 {lT, lC, uT, uC} = 4'h5;
        #12 dq = ~d; // Released lines show no stale data
        msk = ~m;
    endtask : beat
    // Even parity unless bad is set; held four clocks for the synchroniser
    task automatic cmd(input logic [22:0] a, input logic bad, cs);
        csB = cs;
        ca = a;
        par = (^a) ^ bad;
        #20 csB = 1'b1;
        ca = ~a;
        par = ~par;
        #5; // Gap so back-to-back commands never glitch the select
    endtask : cmd
endmodule : sdes_ctrl_model

// [dv/sdes_pins_tb.sv]
// Self-checking bench for the DRAM pin logic block
`timescale 1ns/1ps
module sdes_pins_tb;
    import sdes_pkg::*;
    logic mclk, rst_b, regWr, regRd, vrefLevel, lineTerminationOn, irq_r;
    logic connectivityTestEnable, alertIn, alertOe_r, alertSeen_r, csIn_b;
    logic lowerByteStrobeT, lowerByteStrobeC, cmdAddrParityIn;
    logic upperByteStrobeT, upperByteStrobeC, strobeOe_r, alertOut_b_r;
    logic [1:0] busInvOut_r;
    logic [3:0] regAddr;
    logic [15:0] regWdata, regRdata_r, dqOut_r, dqOe_r, dqIn;
    logic [1:0] writeMaskIn;
    logic [CA_W-1:0] cmdAddrIn;
    int fails, n_compared, k;
    sdes_pins sdes_pins_inst (.mclk, .rst_b, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata_r, .irq_r, .dqIn, .dqOut_r, .dqOe_r,
        .lowerByteStrobeT, .lowerByteStrobeC, .upperByteStrobeT,
        .upperByteStrobeC, .lowerStrobeOutT_r(), .lowerStrobeOutC_r(),
        .upperStrobeOutT_r(), .upperStrobeOutC_r(), .strobeOe_r,
        .writeMaskIn, .busInvOut_r, .busInvOe_r(), .termStrobeTermEn_r(),
        .vrefLevel, .lineTerminationOn, .csIn_b, .cmdAddrIn, .cmdAddrParityIn,
        .connectivityTestEnable, .alertIn, .alertOut_b_r, .alertOe_r,
        .alertSeen_r);
    sdes_ctrl_model sdes_ctrl_model_inst (.dq(dqIn), .lT(lowerByteStrobeT),
        .lC(lowerByteStrobeC), .uT(upperByteStrobeT), .uC(upperByteStrobeC),
        .msk(writeMaskIn), .csB(csIn_b), .ca(cmdAddrIn),
        .par(cmdAddrParityIn));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] s, e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 chk(regRdata_r, e);
    endtask : rc
    initial begin
        #200000;
        fails++;
        close_out();
    end
    initial begin
        {rst_b, regAddr, regWdata, regWr, regRd, vrefLevel} = '0;
        lineTerminationOn = 1'b0;
        connectivityTestEnable = 1'b0;
        alertIn = 1'b1;
        fails = 0;
        n_compared = 0;
        cyc(16);
        rst_b <= 1'b1;
        cyc(2);
        chk(alertOe_r, 0);
        rc(ADDR_STATUS, 16'h0);
        rc(4'hf, 16'h0);
        wr(ADDR_MASK, 16'h3);
        wr(ADDR_CTRL, 16'h0100);
        cyc(3);
        chk(alertOe_r, 1);
        chk(alertOut_b_r, 0);
        chk(irq_r, 1);
        cyc(10);
        chk(alertOe_r, 0);
        rc(ADDR_STATUS, 16'h1);
        wr(ADDR_MASK, 16'h0);
        wr(ADDR_STATUS, 16'h1);
        rc(ADDR_STATUS, 16'h0);
        wr(ADDR_CTRL, 16'h0100);
        cyc(3);
        chk(irq_r, 0);
        wr(ADDR_STATUS, 16'h1);
        wr(ADDR_MASK, 16'h2);
        sdes_ctrl_model_inst.cmd(23'h5, 1'b1, 1'b0);
        cyc(8);
        rc(ADDR_STATUS, 16'h0);
        wr(ADDR_CTRL, 16'h0002);
        for (int i = 0; i < CA_W; i += 11) sdes_ctrl_model_inst.cmd(23'h1 << i,
            1'b0, 1'b0);
        sdes_ctrl_model_inst.cmd(23'h5, 1'b1, 1'b1);
        cyc(8);
        rc(ADDR_STATUS, 16'h0);
        sdes_ctrl_model_inst.cmd(23'h7, 1'b1, 1'b0);
        cyc(8);
        chk(irq_r, 1);
        rc(ADDR_STATUS, 16'h2);
        cyc(60);
        chk(alertOe_r, 1);
        cyc(20);
        chk(alertOe_r, 0);
        wr(ADDR_STATUS, 16'h2);
        wr(ADDR_CTRL, 16'h0004);
        for (int v = 0; v < 2; v++) begin
            @(posedge mclk);
            vrefLevel <= v[0];
            cyc(4);
            chk(dqOut_r[2], v[0]);
        end
        chk(dqOe_r[2], 1);
        wr(ADDR_CTRL, 16'h0);
        sdes_ctrl_model_inst.beat(16'ha55a, 2'h3);
        cyc(6);
        rc(ADDR_RDATA, 16'ha55a);
        wr(ADDR_CTRL, 16'h0010);
        sdes_ctrl_model_inst.beat(16'h1234, 2'h1);
        cyc(6);
        rc(ADDR_RDATA, 16'ha534);
        wr(ADDR_CTRL, 16'h0020);
        sdes_ctrl_model_inst.beat(16'h00f0, 2'h2);
        cyc(6);
        rc(ADDR_RDATA, 16'h000f);
        wr(ADDR_WDATA, 16'h1234);
        wr(ADDR_CRC, 16'h00c3);
        for (int c = 0; c < 2; c++) begin
            wr(ADDR_CTRL, 16'h0);
            wr(ADDR_CTRL, c ? 16'h0081 : 16'h0080);
            k = 0;
            repeat (16) begin
                cyc(1);
                if (dqOe_r === 16'hffff && dqOut_r === 16'h00c3) k++;
            end
            chk(strobeOe_r, 1);
            chk(busInvOut_r, 2'h3);
            chk(k != 0, c[0]);
        end
        wr(ADDR_CTRL, 16'h0);
        @(posedge mclk);
        connectivityTestEnable <= 1'b1;
        alertIn <= 1'b0;
        cyc(4);
        chk(alertSeen_r, 0);
        wr(ADDR_CTRL, 16'h0100);
        cyc(3);
        chk(alertOe_r, 0);
        @(posedge mclk);
        connectivityTestEnable <= 1'b0;
        cyc(4);
        chk(alertSeen_r, 1);
        close_out();
    end
endmodule : sdes_pins_tb
